/* File: core/duty_slew_unit.sv */
// one output's duty slew limiter
`timescale 1ns/1ns
`include "fan_slew_defines.svh"
module duty_slew_unit
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // control
   input wire logic i_update,
   input wire logic i_enable,
   input wire logic i_slow,
   input wire fan_slew_pkg::step_code_t i_step_code,
   input wire fan_slew_pkg::duty_t i_target,
   // result
   output fan_slew_pkg::duty_t o_duty
);
   import fan_slew_pkg::*;

   function automatic duty_t step_size(input step_code_t code);
      case (code)
         3'h0: step_size = `STEP_C0;
         3'h1: step_size = `STEP_C1;
         3'h2: step_size = `STEP_C2;
         3'h3: step_size = `STEP_C3;
         3'h4: step_size = `STEP_C4;
         3'h5: step_size = `STEP_C5;
         3'h6: step_size = `STEP_C6;
         default: step_size = `STEP_C7;
      endcase
   endfunction

   duty_t duty_r;
   duty_t duty_nxt;
   slow_cnt_t slow_r;
   slow_cnt_t slow_nxt;
   duty_t step;

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      duty_nxt = duty_r;
      slow_nxt = slow_r;
      step = step_size(i_step_code);
      if (i_update)
      begin
         if (!i_enable)
         begin
            duty_nxt = i_target;
            slow_nxt = 2'h0;
         end
         else if (i_slow && (slow_r != `SLOW_DIV_LAST))
         begin
            slow_nxt = slow_r + 2'h1;
         end
         else
         begin
            slow_nxt = 2'h0;
            if (i_target > duty_r)
            begin
               if ((i_target - duty_r) < step)
                  duty_nxt = i_target;
               else
                  duty_nxt = duty_r + step;
            end
            else if (i_target < duty_r)
            begin
               if ((duty_r - i_target) < step)
                  duty_nxt = i_target;
               else
                  duty_nxt = duty_r - step;
            end
            else
               duty_nxt = duty_r;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         duty_r <= `REG_RESET;
         slow_r <= 2'h0;
      end
      else
      begin
         duty_r <= duty_nxt;
         slow_r <= slow_nxt;
      end
   end

   assign o_duty = duty_r;
endmodule // duty_slew_unit

/* File: core/fan_pwm_acoustic_ramp_limiter.sv */
// fan duty slew limiter, pwm pins and alarm capture of operating point
`timescale 1ns/1ns
`include "fan_slew_defines.svh"
module fan_pwm_acoustic_ramp_limiter
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // register port
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire fan_slew_pkg::reg_t i_reg_addr,
   input wire fan_slew_pkg::reg_t i_reg_wdata,
   output fan_slew_pkg::reg_t o_reg_rdata,
   // calculated targets
   input wire logic i_target_valid,
   input wire fan_slew_pkg::duty_t i_target_duty1,
   input wire fan_slew_pkg::duty_t i_target_duty2,
   input wire fan_slew_pkg::duty_t i_target_duty3,
   input wire fan_slew_pkg::duty_t i_target_duty4,
   // remote temperatures and alarm
   input wire fan_slew_pkg::reg_t i_remote_temp1,
   input wire fan_slew_pkg::reg_t i_remote_temp2,
   input wire fan_slew_pkg::reg_t i_remote_temp3,
   input wire fan_slew_pkg::reg_t i_remote_temp4,
   input wire logic i_thermal_alarm_input_n,
   // operating points
   output fan_slew_pkg::reg_t o_op_point1,
   output fan_slew_pkg::reg_t o_op_point2,
   output fan_slew_pkg::reg_t o_op_point3,
   output fan_slew_pkg::reg_t o_op_point4,
   // applied duties and fan pins
   output fan_slew_pkg::duty_t o_duty1,
   output fan_slew_pkg::duty_t o_duty2,
   output fan_slew_pkg::duty_t o_duty3,
   output fan_slew_pkg::duty_t o_duty4,
   output logic o_fan_drive_out1,
   output logic o_fan_drive_out2,
   output logic o_fan_drive_out3,
   output logic o_fan_drive_out4
);
   import fan_slew_pkg::*;

   reg_t dyn_ctl_r;
   reg_t dyn_ctl_nxt;
   reg_t acoustic_enhance_one_r;
   reg_t acoustic_enhance_one_nxt;
   reg_t acoustic_enhance_two_r;
   reg_t acoustic_enhance_two_nxt;
   reg_t pwm_cfg_r [4];
   reg_t pwm_cfg_nxt [4];
   reg_t op_point_r [4];
   reg_t op_point_nxt [4];
   reg_t rdata_r;
   reg_t rdata_nxt;
   logic alarm_n_r;
   logic alarm_hit;
   duty_t slot_r;
   duty_t slot_nxt;
   logic [3:0] drive_r;
   logic [3:0] drive_nxt;
   duty_t target [4];
   reg_t remote [4];
   duty_t duty [4];
   logic [3:0] slew_en;
   step_code_t step_code [4];

   function automatic logic addr_is(input reg_t a, input reg_t b);
      addr_is = (a == b);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // register writes and alarm capture
   assign alarm_hit = alarm_n_r && !i_thermal_alarm_input_n;
   assign remote[0] = i_remote_temp1;
   assign remote[1] = i_remote_temp2;
   assign remote[2] = i_remote_temp3;
   assign remote[3] = i_remote_temp4;

   always_comb
   begin
      dyn_ctl_nxt = dyn_ctl_r;
      acoustic_enhance_one_nxt = acoustic_enhance_one_r;
      acoustic_enhance_two_nxt = acoustic_enhance_two_r;
      for (int k = 0; k < 4; k++)
      begin
         pwm_cfg_nxt[k] = pwm_cfg_r[k];
         op_point_nxt[k] = op_point_r[k];
      end
      if (i_reg_wr)
      begin
         if (addr_is(i_reg_addr, `ADDR_DYN_MIN_CTL))
            dyn_ctl_nxt = i_reg_wdata;
         else if (addr_is(i_reg_addr, `ADDR_ACOUSTIC_ONE))
            acoustic_enhance_one_nxt = i_reg_wdata;
         else if (addr_is(i_reg_addr, `ADDR_ACOUSTIC_TWO))
            acoustic_enhance_two_nxt = i_reg_wdata;
         else if (addr_is(i_reg_addr, `ADDR_PWM_CFG1))
            pwm_cfg_nxt[0] = i_reg_wdata;
         else if (addr_is(i_reg_addr, `ADDR_PWM_CFG2))
            pwm_cfg_nxt[1] = i_reg_wdata;
         else if (addr_is(i_reg_addr, `ADDR_PWM_CFG3))
            pwm_cfg_nxt[2] = i_reg_wdata;
         else if (addr_is(i_reg_addr, `ADDR_PWM_CFG4))
            pwm_cfg_nxt[3] = i_reg_wdata;
         else if (addr_is(i_reg_addr, `ADDR_OP_POINT1))
            op_point_nxt[0] = i_reg_wdata;
         else if (addr_is(i_reg_addr, `ADDR_OP_POINT2))
            op_point_nxt[1] = i_reg_wdata;
         else if (addr_is(i_reg_addr, `ADDR_OP_POINT3))
            op_point_nxt[2] = i_reg_wdata;
         else if (addr_is(i_reg_addr, `ADDR_OP_POINT4))
            op_point_nxt[3] = i_reg_wdata;
      end
      // hardware capture wins over a software write in the same cycle
      for (int k = 0; k < 4; k++)
      begin
         if (alarm_hit && dyn_ctl_r[`ALARM_COPY_LSB + k])
            op_point_nxt[k] = remote[k];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register reads
   always_comb
   begin
      rdata_nxt = rdata_r;
      if (i_reg_rd)
      begin
         if (addr_is(i_reg_addr, `ADDR_DYN_MIN_CTL))
            rdata_nxt = dyn_ctl_r;
         else if (addr_is(i_reg_addr, `ADDR_ACOUSTIC_ONE))
            rdata_nxt = acoustic_enhance_one_r;
         else if (addr_is(i_reg_addr, `ADDR_ACOUSTIC_TWO))
            rdata_nxt = acoustic_enhance_two_r;
         else if (addr_is(i_reg_addr, `ADDR_PWM_CFG1))
            rdata_nxt = pwm_cfg_r[0];
         else if (addr_is(i_reg_addr, `ADDR_PWM_CFG2))
            rdata_nxt = pwm_cfg_r[1];
         else if (addr_is(i_reg_addr, `ADDR_PWM_CFG3))
            rdata_nxt = pwm_cfg_r[2];
         else if (addr_is(i_reg_addr, `ADDR_PWM_CFG4))
            rdata_nxt = pwm_cfg_r[3];
         else if (addr_is(i_reg_addr, `ADDR_OP_POINT1))
            rdata_nxt = op_point_r[0];
         else if (addr_is(i_reg_addr, `ADDR_OP_POINT2))
            rdata_nxt = op_point_r[1];
         else if (addr_is(i_reg_addr, `ADDR_OP_POINT3))
            rdata_nxt = op_point_r[2];
         else if (addr_is(i_reg_addr, `ADDR_OP_POINT4))
            rdata_nxt = op_point_r[3];
         else
            rdata_nxt = `REG_RESET;
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         dyn_ctl_r <= `REG_RESET;
         acoustic_enhance_one_r <= `REG_RESET;
         acoustic_enhance_two_r <= `REG_RESET;
         for (int k = 0; k < 4; k++)
         begin
            pwm_cfg_r[k] <= `REG_RESET;
            op_point_r[k] <= `REG_RESET;
         end
         rdata_r <= `REG_RESET;
         alarm_n_r <= 1'b1;
      end
      else
      begin
         dyn_ctl_r <= dyn_ctl_nxt;
         acoustic_enhance_one_r <= acoustic_enhance_one_nxt;
         acoustic_enhance_two_r <= acoustic_enhance_two_nxt;
         for (int k = 0; k < 4; k++)
         begin
            pwm_cfg_r[k] <= pwm_cfg_nxt[k];
            op_point_r[k] <= op_point_nxt[k];
         end
         rdata_r <= rdata_nxt;
         alarm_n_r <= i_thermal_alarm_input_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // per-output slew limiters
   assign slew_en[0] = acoustic_enhance_one_r[`SLEW_EN_LO_BIT];
   assign slew_en[1] = acoustic_enhance_one_r[`SLEW_EN_HI_BIT];
   assign slew_en[2] = acoustic_enhance_two_r[`SLEW_EN_LO_BIT];
   assign slew_en[3] = acoustic_enhance_two_r[`SLEW_EN_HI_BIT];
   assign step_code[0] = acoustic_enhance_one_r[`STEP_LO_MSB:`STEP_LO_LSB];
   assign step_code[1] = acoustic_enhance_one_r[`STEP_HI_MSB:`STEP_HI_LSB];
   assign step_code[2] = acoustic_enhance_two_r[`STEP_LO_MSB:`STEP_LO_LSB];
   assign step_code[3] = acoustic_enhance_two_r[`STEP_HI_MSB:`STEP_HI_LSB];
   assign target[0] = i_target_duty1;
   assign target[1] = i_target_duty2;
   assign target[2] = i_target_duty3;
   assign target[3] = i_target_duty4;

   for (genvar g = 0; g < 4; g++)
   begin : g_slew
      duty_slew_unit u_slew
      (
         .i_clk(i_clk),
         .i_sys_rst(i_sys_rst),
         .i_update(i_target_valid),
         .i_enable(slew_en[g]),
         .i_slow(pwm_cfg_r[g][`SLOW_BIT]),
         .i_step_code(step_code[g]),
         .i_target(target[g]),
         .o_duty(duty[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // 255-slot pwm period
   always_comb
   begin
      slot_nxt = (slot_r == `LAST_SLOT) ? 8'h00 : slot_r + 8'h01;
      for (int k = 0; k < 4; k++)
         drive_nxt[k] = (slot_r < duty[k]);
   end

   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         slot_r <= 8'h00;
         drive_r <= 4'h0;
      end
      else
      begin
         slot_r <= slot_nxt;
         drive_r <= drive_nxt;
      end
   end

   assign o_reg_rdata = rdata_r;
   assign o_op_point1 = op_point_r[0];
   assign o_op_point2 = op_point_r[1];
   assign o_op_point3 = op_point_r[2];
   assign o_op_point4 = op_point_r[3];
   assign o_duty1 = duty[0];
   assign o_duty2 = duty[1];
   assign o_duty3 = duty[2];
   assign o_duty4 = duty[3];
   assign o_fan_drive_out1 = drive_r[0];
   assign o_fan_drive_out2 = drive_r[1];
   assign o_fan_drive_out3 = drive_r[2];
   assign o_fan_drive_out4 = drive_r[3];
endmodule // fan_pwm_acoustic_ramp_limiter

/* File: pkg/fan_slew_defines.svh */
// constants for the fan duty slew limiter
// Behaviour
// - dynamic control bits 5:2 enable alarm copy
// - alarm with bit set copies remote temperature
// - alarm with bit clear leaves operating point
// - slew off: new duty applied at once
// - slew on: duty change per update capped
// - first acoustic register enables outputs one, two
// - second acoustic register enables outputs three, four
// - each output has independent slew enable
// - period has 255 slots; duty counts high slots
// - one slot is smallest duty step
// - target above previous: raise by selected step
// - target below previous: lower by selected step
// - stepped result becomes next previous value
// - bits 4:2 select step, outputs one, three
// - bits 7:5 select step, outputs two, four
// - slow bit makes ramp four times slower
`ifndef FAN_SLEW_DEFINES_SVH
`define FAN_SLEW_DEFINES_SVH
`define ADDR_DYN_MIN_CTL 8'h0B
`define ADDR_ACOUSTIC_ONE 8'h1A
`define ADDR_ACOUSTIC_TWO 8'h1B
`define ADDR_PWM_CFG1 8'h21
`define ADDR_PWM_CFG2 8'h22
`define ADDR_PWM_CFG3 8'h23
`define ADDR_PWM_CFG4 8'h24
`define ADDR_OP_POINT1 8'h40
`define ADDR_OP_POINT2 8'h41
`define ADDR_OP_POINT3 8'h42
`define ADDR_OP_POINT4 8'h43
`define REG_RESET 8'h00
`define ALARM_COPY_LSB 2
`define SLEW_EN_LO_BIT 0
`define SLEW_EN_HI_BIT 1
`define STEP_LO_MSB 4
`define STEP_LO_LSB 2
`define STEP_HI_MSB 7
`define STEP_HI_LSB 5
`define SLOW_BIT 3
`define SLOW_DIV_LAST 2'h3
`define LAST_SLOT 8'hFE
`define STEP_C0 8'h01
`define STEP_C1 8'h02
`define STEP_C2 8'h03
`define STEP_C3 8'h05
`define STEP_C4 8'h08
`define STEP_C5 8'h0C
`define STEP_C6 8'h18
`define STEP_C7 8'h30
`endif

/* File: pkg/fan_slew_pkg.sv */
// types shared by the fan duty slew limiter
package fan_slew_pkg;
   typedef logic [7:0] duty_t;
   typedef logic [7:0] reg_t;
   typedef logic [2:0] step_code_t;
   typedef logic [1:0] slow_cnt_t;
endpackage

/* File: tb/fan_alarm_model.sv */
// far side: thermal alarm source and fan pulse counter
`timescale 1ns/1ns
module fan_alarm_model
(
   // clock
   input wire logic i_clk,
   // fan pins watched, out1 in bit 0
   input wire logic [3:0] i_fan_pins,
   // alarm pin driven, idle high
   output logic o_alarm_n
);
   initial o_alarm_n = 1'b1;
   // pull the alarm low for n cycles, then release it
   task automatic pulse(input int n);
      @(posedge i_clk) #5 o_alarm_n = 1'b0;
      repeat (n) @(posedge i_clk);
      #5 o_alarm_n = 1'b1;
   endtask
   // high slots seen on each pin over one whole period, sampled once settled
   task automatic count_high(output int h1, output int h2, output int h3, output int h4);
      h1 = 0;
      h2 = 0;
      h3 = 0;
      h4 = 0;
      repeat (255)
      begin
         @(posedge i_clk) #5;
         h1 += int'(i_fan_pins[0]);
         h2 += int'(i_fan_pins[1]);
         h3 += int'(i_fan_pins[2]);
         h4 += int'(i_fan_pins[3]);
      end
   endtask
endmodule // fan_alarm_model

/* File: tb/fan_pwm_acoustic_ramp_limiter_tb.sv */
// self-checking bench for the fan duty slew limiter
`timescale 1ns/1ns
module fan_pwm_acoustic_ramp_limiter_tb;
   import fan_slew_pkg::*;
   localparam duty_t STEPS [8] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0C, 8'h18, 8'h30};
   localparam reg_t ADDRS [6] = '{8'h0B, 8'h1A, 8'h1B, 8'h21, 8'h40, 8'h55};
   logic i_clk, i_thermal_alarm_input_n;
   logic i_sys_rst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_target_valid = 1'b0;
   reg_t i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata;
   duty_t i_target_duty1 = 8'h00, i_target_duty2 = 8'h00;
   duty_t i_target_duty3 = 8'h00, i_target_duty4 = 8'h00;
   reg_t i_remote_temp1 = 8'h3C, i_remote_temp2 = 8'h4D;
   reg_t i_remote_temp3 = 8'h5E, i_remote_temp4 = 8'h6F;
   reg_t o_op_point1, o_op_point2, o_op_point3, o_op_point4;
   duty_t o_duty1, o_duty2, o_duty3, o_duty4, s;
   logic o_fan_drive_out1, o_fan_drive_out2, o_fan_drive_out3, o_fan_drive_out4;
   int n_errors = 0;
   int samples_checked = 0;
   int hi1, hi2, hi3, hi4;
   fan_pwm_acoustic_ramp_limiter u_dut (.i_clk, .i_sys_rst, .i_reg_wr, .i_reg_rd,
      .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .i_target_valid, .i_target_duty1,
      .i_target_duty2, .i_target_duty3, .i_target_duty4, .i_remote_temp1,
      .i_remote_temp2, .i_remote_temp3, .i_remote_temp4, .i_thermal_alarm_input_n,
      .o_op_point1, .o_op_point2, .o_op_point3, .o_op_point4, .o_duty1, .o_duty2,
      .o_duty3, .o_duty4, .o_fan_drive_out1, .o_fan_drive_out2, .o_fan_drive_out3,
      .o_fan_drive_out4);
   fan_alarm_model u_far (.i_clk(i_clk),
      .i_fan_pins({o_fan_drive_out4, o_fan_drive_out3, o_fan_drive_out2, o_fan_drive_out1}),
      .o_alarm_n(i_thermal_alarm_input_n));
   ////////////////////////////////////////////////////////////////
   // clock and watchdog
   initial
   begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   initial
   begin
      #1000000;
      n_errors++;
      wrap_up();
   end
   ////////////////////////////////////////////////////////////////
   // access and compare tasks
   task automatic cmp(input duty_t got, input duty_t exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input reg_t a, input reg_t d);
      i_reg_wr = 1'b1;
      i_reg_addr = a;
      i_reg_wdata = d;
      @(posedge i_clk) #5 i_reg_wr = 1'b0;
      @(posedge i_clk) #5;
   endtask
   task automatic rd(input reg_t a, input reg_t e);
      i_reg_rd = 1'b1;
      i_reg_addr = a;
      @(posedge i_clk) #5 i_reg_rd = 1'b0;
      @(posedge i_clk) #5 cmp(o_reg_rdata, e);
   endtask
   task automatic tgt(input duty_t a, input duty_t b, input duty_t c, input duty_t d);
      i_target_valid = 1'b1;
      {i_target_duty1, i_target_duty2, i_target_duty3, i_target_duty4} = {a, b, c, d};
      @(posedge i_clk) #5 i_target_valid = 1'b0;
      @(posedge i_clk) #5;
   endtask
   task automatic duties(input duty_t a, input duty_t b, input duty_t c, input duty_t d);
      cmp(o_duty1, a);
      cmp(o_duty2, b);
      cmp(o_duty3, c);
      cmp(o_duty4, d);
   endtask
   task automatic pins(input duty_t a, input duty_t b, input duty_t c, input duty_t d);
      cmp(duty_t'(hi1), a);
      cmp(duty_t'(hi2), b);
      cmp(duty_t'(hi3), c);
      cmp(duty_t'(hi4), d);
   endtask
   task automatic ops(input reg_t a, input reg_t b, input reg_t c, input reg_t d);
      cmp(o_op_point1, a);
      cmp(o_op_point2, b);
      cmp(o_op_point3, c);
      cmp(o_op_point4, d);
   endtask
   task automatic wrap_up;
      $display("mismatches %0d, comparisons %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      repeat (8) @(posedge i_clk);
      #5 i_sys_rst = 1'b0;
      wr(8'h55, 8'hFF);
      foreach (ADDRS[i]) rd(ADDRS[i], 8'h00);
      wr(8'h1B, 8'hE0);
      rd(8'h1B, 8'hE0);
      tgt(8'h55, 8'h14, 8'h00, 8'hFF);
      duties(8'h55, 8'h14, 8'h00, 8'hFF);
      u_far.count_high(hi1, hi2, hi3, hi4);
      pins(8'h55, 8'h14, 8'h00, 8'hFF);
      tgt(8'hFF, 8'h14, 8'h00, 8'hFF);
      u_far.count_high(hi1, hi2, hi3, hi4);
      pins(8'hFF, 8'h14, 8'h00, 8'hFF);
      for (int k = 0; k < 8; k++)
      begin
         s = STEPS[k];
         wr(8'h1A, 8'h00);
         wr(8'h1B, 8'h00);
         tgt(8'h64, 8'h64, 8'h64, 8'h64);
         wr(8'h1A, {k[2:0], k[2:0], 2'b01});
         wr(8'h1B, {k[2:0], k[2:0], 2'b11});
         tgt(8'hC8, 8'hC8, 8'hC8, 8'hC8);
         duties(8'h64 + s, 8'hC8, 8'h64 + s, 8'h64 + s);
         tgt(8'h00, 8'h00, 8'h00, 8'h00);
         duties(8'h64, 8'h00, 8'h64, 8'h64);
         tgt(8'h64, 8'h00, 8'h65, 8'h64);
         duties(8'h64, 8'h00, 8'h65, 8'h64);
      end
      wr(8'h1A, 8'h00);
      tgt(8'h00, 8'h00, 8'h00, 8'h00);
      wr(8'h21, 8'h08);
      wr(8'h1A, 8'h11);
      for (int k = 1; k <= 4; k++)
      begin
         tgt(8'h28, 8'h00, 8'h00, 8'h00);
         cmp(o_duty1, (k == 4) ? 8'h08 : 8'h00);
      end
      wr(8'h0B, 8'h14);
      for (int k = 0; k < 4; k++) wr(8'h40 + k[7:0], 8'h11);
      u_far.pulse(3);
      @(posedge i_clk) #5;
      ops(8'h3C, 8'h11, 8'h5E, 8'h11);
      for (int k = 0; k < 4; k++)
      begin
         s = (k == 0) ? 8'h3C : (k == 2) ? 8'h5E : 8'h11;
         rd(8'h40 + k[7:0], s);
      end
      wr(8'h0B, 8'h28);
      i_remote_temp1 = 8'h50;
      u_far.pulse(3);
      @(posedge i_clk) #5;
      ops(8'h3C, 8'h4D, 8'h5E, 8'h6F);
      rd(8'h40, 8'h3C);
      rd(8'h43, 8'h6F);
      wrap_up();
   end
endmodule // fan_pwm_acoustic_ramp_limiter_tb

/* File: tb/fan_ramp_checker_sva.sv */
// assertion checker for the fan duty slew limiter
`timescale 1ns/1ns
module fan_ramp_checker
   import fan_slew_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // inputs watched
   input wire logic i_reg_wr,
   input wire fan_slew_pkg::reg_t i_reg_addr,
   input wire fan_slew_pkg::reg_t i_reg_wdata,
   input wire logic i_target_valid,
   input wire fan_slew_pkg::duty_t i_target_duty1,
   input wire fan_slew_pkg::duty_t i_target_duty2,
   input wire fan_slew_pkg::reg_t i_remote_temp1,
   input wire logic i_thermal_alarm_input_n,
   // outputs watched
   input wire fan_slew_pkg::reg_t o_op_point1,
   input wire fan_slew_pkg::duty_t o_duty1,
   input wire fan_slew_pkg::duty_t o_duty2,
   input wire logic o_fan_drive_out1
);
   localparam duty_t STEPS [8] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0C, 8'h18, 8'h30};
   reg_t dyn_r, ac_r, cfg_r;
   duty_t step;
   logic on1;
   ////////////////////////////////////////////////////////////////
   // shadow of the control registers
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         dyn_r <= 8'h00;
         ac_r <= 8'h00;
         cfg_r <= 8'h00;
      end
      else if (i_reg_wr)
      begin
         if (i_reg_addr == 8'h0B) dyn_r <= i_reg_wdata;
         if (i_reg_addr == 8'h1A) ac_r <= i_reg_wdata;
         if (i_reg_addr == 8'h21) cfg_r <= i_reg_wdata;
      end
   end
   assign step = STEPS[ac_r[4:2]];
   assign on1 = ac_r[0] && !cfg_r[3];
   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   AST_SLEW_OFF: assert property (
      i_target_valid && !ac_r[0] |=> o_duty1 == $past(i_target_duty1))
      else $error("duty1 not applied at once");
   AST_RAISE: assert property (
      i_target_valid && on1 && i_target_duty1 > o_duty1 |=> o_duty1 ==
      (($past(i_target_duty1) - $past(o_duty1)) > $past(step) ?
      $past(o_duty1) + $past(step) : $past(i_target_duty1)))
      else $error("duty1 raise wrong");
   AST_LOWER: assert property (
      i_target_valid && on1 && i_target_duty1 < o_duty1 |=> o_duty1 ==
      (($past(o_duty1) - $past(i_target_duty1)) > $past(step) ?
      $past(o_duty1) - $past(step) : $past(i_target_duty1)))
      else $error("duty1 lower wrong");
   AST_EQUAL: assert property (
      i_target_valid && i_target_duty1 == o_duty1 |=> $stable(o_duty1))
      else $error("duty1 moved on equal target");
   AST_NO_UPDATE: assert property (!i_target_valid |=> $stable(o_duty1))
      else $error("duty1 moved without update");
   AST_OTHER_OUT: assert property (
      i_target_valid && !ac_r[1] |=> o_duty2 == $past(i_target_duty2))
      else $error("duty2 not applied at once");
   AST_CAPTURE: assert property (
      $fell(i_thermal_alarm_input_n) && dyn_r[2] |=> o_op_point1 == $past(i_remote_temp1))
      else $error("operating point not captured");
   AST_NO_CAPTURE: assert property (
      !dyn_r[2] && !(i_reg_wr && i_reg_addr == 8'h40) |=> $stable(o_op_point1))
      else $error("operating point changed");
   AST_PIN_LOW: assert property ((o_duty1 == 8'h00) [*3] |-> !o_fan_drive_out1)
      else $error("pin high at zero duty");
   AST_PIN_HIGH: assert property ((o_duty1 == 8'hFF) [*3] |-> o_fan_drive_out1)
      else $error("pin low at full duty");
endmodule // fan_ramp_checker

bind fan_pwm_acoustic_ramp_limiter fan_ramp_checker u_chk (.i_clk, .i_sys_rst, .i_reg_wr,
   .i_reg_addr, .i_reg_wdata, .i_target_valid, .i_target_duty1, .i_target_duty2,
   .i_remote_temp1, .i_thermal_alarm_input_n, .o_op_point1, .o_duty1, .o_duty2,
   .o_fan_drive_out1);
